// File: shared/conv_serial_pkg.sv
// shared constants for the converter serial frame and power-mode control
package conv_serial_pkg;
	localparam int          RESULT_WIDTH    = 12;
	localparam int          LEAD_ZEROS      = 3;
	localparam int          FRAME_EDGES     = 16;
	localparam int          COUNT_WIDTH     = 5;
	localparam logic [4:0]  GLITCH_EDGES    = 5'h02;
	localparam logic [4:0]  KEEP_EDGES      = 5'h0A;
	localparam logic [4:0]  LAST_EDGE       = 5'h10;
	localparam logic [4:0]  TRACK_RISE      = 5'h0D;
	localparam logic [3:0]  FIRST_BIT_IDX   = 4'hF;
	localparam logic [11:0] RESULT_RESET    = 12'h000;
	localparam logic        POWER_UP_MODE   = 1'b0;
	localparam int          BUF_DEPTH       = 2;
	typedef enum logic [1:0] {
		IDLE_TRACK,
		HOLD_CONVERT,
		FRAME_DONE
	} frame_state_type;
endpackage

// File: logic/result_buffer.sv
// two-entry valid/ready buffer for finished conversion words
`timescale 1ns/100ps
module result_buffer (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// fill side
	input  wire logic        fill_valid_in,
	input  wire logic [11:0] fill_data_in,
	output logic             fill_ready_out,
	// drain side
	output logic             drain_valid_out,
	output logic [11:0]      drain_data_out,
	input  wire logic        drain_ready_in
);
	logic [11:0] store [conv_serial_pkg::BUF_DEPTH];
	logic        wr_ptr;
	logic        rd_ptr;
	logic [1:0]  fill_count;
	wire         push = fill_valid_in && fill_ready_out;
	wire         pop  = drain_valid_out && drain_ready_in;

	assign fill_ready_out  = (fill_count != 2'(conv_serial_pkg::BUF_DEPTH));
	assign drain_valid_out = (fill_count != 2'h0);

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr     <= 1'b0;
			rd_ptr     <= 1'b0;
			fill_count <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			fill_count <= fill_count + {1'b0, push} - {1'b0, pop};
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (push)
			store[wr_ptr] <= fill_data_in;
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			drain_data_out <= 12'h000;
		else if (pop && fill_count == 2'(conv_serial_pkg::BUF_DEPTH))
			drain_data_out <= store[~rd_ptr];
		else if (push && (fill_count == 2'h0 || (pop && fill_count == 2'h1)))
			drain_data_out <= fill_data_in;
	end
endmodule

// File: logic/conv_serial_ctrl.sv
// serial frame sequencing and power-mode control of the sampling converter
// Notes on behaviour
// - a falling chip select starts a conversion and the falling-edge count.
// - rise between tenth and sixteenth edges aborts, stays normal, floats output.
// - after the sixteenth edge the data output floats without chip select.
// - rise between second and tenth edges enters shutdown and aborts.
// - rise before the second edge leaves the power mode unchanged.
// - falling chip select in shutdown powers up; that first result is invalid.
// - waking frame ended before the tenth edge returns to shutdown.
// - waking frame held past tenth edge is fully powered after sixteen clocks.
// - initial mode after supply is undefined; here a reset constant.
// - output is three zeros then twelve result bits, msb first, on falling edges.
// - falling chip select samples input, drives output, and holds.
// - tracking resumes on thirteenth rising edge; host allows acquisition interval.
`timescale 1ns/100ps
module conv_serial_ctrl (
	// clock and reset
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	// serial pins
	input  wire logic        chip_sel_n_in,
	input  wire logic        bit_clk_in,
	output logic             serial_result_out,
	output logic             serial_result_oe_out,
	// converter core side
	input  wire logic [11:0] sample_value_in,
	output logic             holding_out,
	output logic             shutdown_out,
	// finished word stream
	output logic             word_valid_out,
	output logic [11:0]      word_data_out,
	input  wire logic        word_ready_in,
	output logic             word_dropped_out
);
	logic            cs_meta;
	logic            cs_sync;
	logic            cs_last;
	logic            clk_meta;
	logic            clk_sync;
	logic            clk_last;
	logic [4:0]      fall_count;
	logic [4:0]      rise_count;
	logic [11:0]     sample_hold;
	logic            shutdown;
	logic            waking;
	logic            result_valid;
	logic            push_word;
	logic            buf_ready;
	conv_serial_pkg::frame_state_type state;
	conv_serial_pkg::frame_state_type next_state;

	wire cs_fall   = cs_last && !cs_sync;
	wire cs_rise   = !cs_last && cs_sync;
	wire sclk_fall = clk_last && !clk_sync;
	wire sclk_rise = !clk_last && clk_sync;
	wire in_frame  = (state == conv_serial_pkg::HOLD_CONVERT);
	wire last_fall = in_frame && sclk_fall && (fall_count == conv_serial_pkg::LAST_EDGE - 5'h01);
	wire early_end = cs_rise && in_frame && (fall_count < conv_serial_pkg::GLITCH_EDGES);
	wire sleep_end = cs_rise && in_frame && !early_end && (fall_count < conv_serial_pkg::KEEP_EDGES);
	// the fall seen now is number fall_count + 1; after fall n the frame shows bit 15 - n
	wire [4:0] bit_pos = fall_count + 5'h01;
	wire [3:0] shift_idx = conv_serial_pkg::FIRST_BIT_IDX - bit_pos[3:0];
	// one zero at the select fall plus the three leading zeros, then the result
	wire [15:0] frame_word = {{(conv_serial_pkg::LEAD_ZEROS + 1){1'b0}}, sample_hold};

	assign shutdown_out = shutdown;
	assign word_dropped_out = push_word && !buf_ready;

	// two-stage sampling of both pins; edges compare the second stage with a third register
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cs_meta  <= 1'b1;
			cs_sync  <= 1'b1;
			cs_last  <= 1'b1;
			clk_meta <= 1'b0;
			clk_sync <= 1'b0;
			clk_last <= 1'b0;
		end else begin
			cs_meta  <= chip_sel_n_in;
			cs_sync  <= cs_meta;
			cs_last  <= cs_sync;
			clk_meta <= bit_clk_in;
			clk_sync <= clk_meta;
			clk_last <= clk_sync;
		end
	end

	// a new frame needs a fresh fall, so an idle-low select stays done
	always_comb begin
		next_state = state;
		unique case (state)
			conv_serial_pkg::IDLE_TRACK:   if (cs_fall) next_state = conv_serial_pkg::HOLD_CONVERT;
			conv_serial_pkg::HOLD_CONVERT: begin
				if (cs_rise)
					next_state = conv_serial_pkg::IDLE_TRACK;
				else if (last_fall)
					next_state = conv_serial_pkg::FRAME_DONE;
			end
			conv_serial_pkg::FRAME_DONE:   if (cs_rise) next_state = conv_serial_pkg::IDLE_TRACK;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			state <= conv_serial_pkg::IDLE_TRACK;
		else
			state <= next_state;
	end

	// counters clear on each select edge and count within the frame
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			fall_count <= 5'h00;
			rise_count <= 5'h00;
		end else if (cs_fall || cs_rise) begin
			fall_count <= 5'h00;
			rise_count <= 5'h00;
		end else if (in_frame) begin
			if (sclk_fall)
				fall_count <= fall_count + 5'h01;
			if (sclk_rise)
				rise_count <= rise_count + 5'h01;
		end
	end

	// sample and hold on the falling select; track on thirteenth rise
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sample_hold <= conv_serial_pkg::RESULT_RESET;
			holding_out <= 1'b0;
		end else if (cs_fall && state == conv_serial_pkg::IDLE_TRACK) begin
			sample_hold <= sample_value_in;
			holding_out <= 1'b1;
		end else if (cs_rise || (in_frame && sclk_rise && rise_count == conv_serial_pkg::TRACK_RISE - 5'h01)) begin
			holding_out <= 1'b0;
		end
	end

	// power-up mode is undefined; reset picks a fixed constant
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			shutdown     <= conv_serial_pkg::POWER_UP_MODE;
			waking       <= 1'b0;
			result_valid <= 1'b0;
		end else if (cs_fall && state == conv_serial_pkg::IDLE_TRACK) begin
			// leaving shutdown, this frame's result is invalid
			waking       <= shutdown;
			result_valid <= !shutdown;
			shutdown     <= 1'b0;
		end else if (early_end) begin
			// glitch protection keeps the mode held before the frame
			// a waking frame ended early goes back to sleep
			shutdown <= waking;
		end else if (sleep_end) begin
			shutdown <= 1'b1;
		end else if (cs_rise && in_frame) begin
			// late rise keeps normal mode; waking frame stays awake
			shutdown <= 1'b0;
			waking   <= 1'b0;
		end else if (last_fall) begin
			waking <= 1'b0;
		end
	end

	// three zeros then result msb first; float on abort or end
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			serial_result_out    <= 1'b0;
			serial_result_oe_out <= 1'b0;
		end else if (cs_rise || last_fall) begin
			serial_result_out    <= 1'b0;
			serial_result_oe_out <= 1'b0;
		end else if (cs_fall && state == conv_serial_pkg::IDLE_TRACK) begin
			serial_result_out    <= 1'b0;
			serial_result_oe_out <= 1'b1;
		end else if (in_frame && sclk_fall) begin
			serial_result_out    <= frame_word[shift_idx];
		end
	end

	// a completed valid frame hands the word on
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			push_word <= 1'b0;
		else
			push_word <= last_fall && result_valid;
	end

	// a full buffer drops the new word and flags it for one cycle
	result_buffer word_buffer (
		.sys_clk_in      (sys_clk_in),
		.rst_n_in        (rst_n_in),
		.fill_valid_in   (push_word),
		.fill_data_in    (sample_hold),
		.fill_ready_out  (buf_ready),
		.drain_valid_out (word_valid_out),
		.drain_data_out  (word_data_out),
		.drain_ready_in  (word_ready_in)
	);

	tristate_end_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		last_fall |=> !serial_result_oe_out)
		else $error("data output still driven after last edge");
	abort_float_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		cs_rise |=> !serial_result_oe_out)
		else $error("data output driven after select rise");
	shutdown_entry_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		sleep_end |=> shutdown)
		else $error("mid frame rise did not enter shutdown");
	glitch_keep_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(early_end && !waking) |=> shutdown == $past(shutdown))
		else $error("early rise changed the mode");
	wake_return_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(cs_rise && in_frame && waking && fall_count < conv_serial_pkg::KEEP_EDGES) |=> shutdown)
		else $error("waking frame did not return to shutdown");
	late_normal_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(cs_rise && in_frame && fall_count >= conv_serial_pkg::KEEP_EDGES) |=> !shutdown)
		else $error("late rise left normal mode");
	wake_drop_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(last_fall && waking) |=> !push_word)
		else $error("invalid waking result was delivered");
	frame_start_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(cs_fall && state == conv_serial_pkg::IDLE_TRACK)
		|=> serial_result_oe_out && holding_out && fall_count == 5'h00)
		else $error("frame start did not drive and hold");
endmodule

// File: test/host_serial_model.sv
// host-side serial controller: frames, bit clock and result capture
`timescale 1ns/100ps
module host_serial_model (
	// serial pins
	output logic      chip_sel_n_out,
	output logic      bit_clk_out,
	input  wire logic serial_result_in,
	input  wire logic serial_result_oe_in,
	// converter state
	input  wire logic holding_in
);
	logic line;
	logic last;
	// a released data line shows the inverse of its last level, never a stale copy
	assign line = serial_result_oe_in ? serial_result_in : ~last;
	always @* begin
		if (serial_result_oe_in) begin
			last = serial_result_in;
		end
	end
	initial begin
		last = 1'b0;
		chip_sel_n_out = 1'b1;
		bit_clk_out = 1'b0;
	end
	// rise k samples the bit driven after fall k-1; the clock rests low between frames
	task automatic frame(input int falls, output logic [15:0] bits, output logic [1:0] hold, output logic oe_end);
		bits = 16'h0000;
		hold = 2'b00;
		chip_sel_n_out = 1'b0;
		for (int k = 1; k <= falls; k++) begin
			#62.5;
			bit_clk_out = 1'b1;
			bits[16 - k] = line;
			if (k == 1) hold[1] = holding_in;
			if (k == 16) hold[0] = holding_in;
			#62.5;
			bit_clk_out = 1'b0;
		end
		#62.5;
		oe_end = serial_result_oe_in;
		chip_sel_n_out = 1'b1;
		#400;
	endtask
endmodule

// File: test/adc_serial_power_mode_control_test.sv
// self-checking bench for converter serial frame and power-mode control
`timescale 1ns/100ps
module adc_serial_power_mode_control_test;
	logic        sys_clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	logic [11:0] sample_value_in = 12'h000;
	logic        word_ready_in = 1'b0;
	logic        chip_sel_n;
	logic        bit_clk;
	logic        serial_result_out;
	logic        serial_result_oe_out;
	logic        holding_out;
	logic        shutdown_out;
	logic        word_valid_out;
	logic [11:0] word_data_out;
	logic        word_dropped_out;
	logic [15:0] bits;
	logic [1:0]  hold;
	logic        oe_end;
	int          n_fail = 0;
	int          compares = 0;
	int          n_drop = 0;

	always #5 sys_clk_in = ~sys_clk_in;
	// drop pulses are counted away from the edge that launches them
	always @(negedge sys_clk_in) begin
		if (word_dropped_out === 1'b1) n_drop <= n_drop + 1;
	end

	conv_serial_ctrl uut (
		.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .chip_sel_n_in(chip_sel_n), .bit_clk_in(bit_clk),
		.serial_result_out(serial_result_out), .serial_result_oe_out(serial_result_oe_out),
		.sample_value_in(sample_value_in), .holding_out(holding_out), .shutdown_out(shutdown_out),
		.word_valid_out(word_valid_out), .word_data_out(word_data_out), .word_ready_in(word_ready_in),
		.word_dropped_out(word_dropped_out)
	);
	host_serial_model host (
		.chip_sel_n_out(chip_sel_n), .bit_clk_out(bit_clk), .serial_result_in(serial_result_out),
		.serial_result_oe_in(serial_result_oe_out), .holding_in(holding_out)
	);

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic end_sim;
		if (n_fail == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic run(input int falls, input logic [11:0] value);
		@(posedge sys_clk_in);
		sample_value_in <= value;
		@(posedge sys_clk_in);
		#3;
		host.frame(falls, bits, hold, oe_end);
	endtask

	task automatic pop;
		@(posedge sys_clk_in);
		word_ready_in <= 1'b1;
		@(posedge sys_clk_in);
		word_ready_in <= 1'b0;
		#1;
	endtask

	task automatic t_full;
		run(16, 12'hA5C);
		check("frame bits", bits, 16'h0A5C);
		check("holding", hold, 2'b10);
		check("float after last edge", oe_end, 1'b0);
		check("word", word_data_out, 12'hA5C);
		check("mode", shutdown_out, 1'b0);
		pop;
	endtask

	task automatic t_modes;
		int   falls[9] = '{1, 5, 1, 16, 12, 9, 10, 2, 16};
		logic sd[9] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		logic was_sd;
		for (int i = 0; i < 9; i++) begin
			was_sd = shutdown_out;
			run(falls[i], 12'h3C0);
			check("mode", shutdown_out, sd[i]);
			check("drive until rise", oe_end, falls[i] < 16);
			check("float after rise", serial_result_oe_out, 1'b0);
			check("word kept", word_valid_out, falls[i] == 16 && !was_sd);
			if (word_valid_out === 1'b1) pop;
		end
	endtask

	task automatic t_buffer;
		for (int i = 1; i <= 3; i++) begin
			run(16, 12'(i));
		end
		check("drops", n_drop[15:0], 16'h0001);
		check("first", word_data_out, 12'h001);
		pop;
		check("second", word_data_out, 12'h002);
		pop;
		check("empty", word_valid_out, 1'b0);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		check("reset mode", shutdown_out, 1'b0);
		check("reset valid", word_valid_out, 1'b0);
		run(16, 12'h000);
		pop;
		t_full;
		t_modes;
		t_buffer;
		end_sim;
	end

	initial begin
		#200000;
		n_fail++;
		end_sim;
	end
endmodule
